//--- hw/dpt_pkg.sv
// Constants, register map and state types of the delay and pulse timer
package dpt_pkg;
	// -----------------------------------------------------------------
	// Time base
	// -----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned TICK_PERIOD_MS = 10;
	localparam int unsigned NS_PER_MS = 1_000_000;
	localparam int unsigned TICK_CYC_DFLT =
		TICK_PERIOD_MS * NS_PER_MS / CLK_PERIOD_NS;
	localparam int unsigned SEC_TICKS = 100;
	localparam int unsigned MIN_SECS = 60;
	// -----------------------------------------------------------------
	// Widths and limits
	// -----------------------------------------------------------------
	localparam int unsigned SRC_CNT = 4;
	localparam int unsigned EXT_W = 20;
	localparam int unsigned DLY_W = 16;
	localparam logic [EXT_W-1:0] EXT_ZERO = 20'h0_0000;
	localparam logic [EXT_W-1:0] EXT_MAX_MS = 20'h1_8696;
	localparam logic [EXT_W-1:0] EXT_MAX_UNIT = 20'h0_176F;
	localparam logic [EXT_W-1:0] FIX_MAX_FINE = 20'h0_270F;
	localparam logic [EXT_W-1:0] FIX_MAX_UNIT = 20'h0_176F;
	localparam logic [EXT_W-1:0] EXT_MS_PER_TICK = 20'h0_000A;
	localparam logic [DLY_W-1:0] DLY_ZERO = 16'h0000;
	localparam logic [DLY_W-1:0] DLY_ONE = 16'h0001;
	localparam logic [DLY_W-1:0] DLY_SAT = 16'hFFFF;
	// -----------------------------------------------------------------
	// Register map
	// -----------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_HIGH = 8'h04;
	localparam logic [7:0] REG_LOW = 8'h08;
	localparam logic [7:0] REG_SRC = 8'h0C;
	localparam logic [7:0] REG_STAT = 8'h10;
	localparam logic [7:0] REG_ELAP = 8'h14;
	localparam logic [7:0] REG_EFF = 8'h18;
	localparam int unsigned CTRL_MODE_LSB = 0;
	localparam int unsigned CTRL_RET_BIT = 2;
	localparam int unsigned CTRL_EXT_BIT = 3;
	localparam int unsigned CTRL_BASE_LSB = 4;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
	// -----------------------------------------------------------------
	// Modes, time bases and states
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_OFFDLY = 2'h0,
		MODE_ONOFF = 2'h1,
		MODE_RETON = 2'h2,
		MODE_PULSE = 2'h3
	} dpt_mode_e;
	localparam logic [1:0] BASE_FINE = 2'h0;
	localparam logic [1:0] BASE_SEC = 2'h1;
	localparam logic [1:0] BASE_MIN = 2'h2;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_TIME = 2'b01,
		ST_ON = 2'b11,
		ST_HOLD = 2'b10
	} dpt_state_e;
endpackage : dpt_pkg

//--- hw/dpt_time_if.sv
// Delay source and time base signals shared by the timer modules
`timescale 1ns/1ps
interface dpt_time_if;
	logic [15:0] fixedT;
	logic srcExt;
	logic [1:0] blkSel;
	logic [1:0] baseSel;
	logic [15:0] delayT;
	logic [1:0] unitSel;
	logic tick;
	modport selPort(input fixedT, srcExt, blkSel, baseSel,
		output delayT, unitSel);
	modport tickPort(input unitSel, output tick);
	modport corePort(output fixedT, srcExt, blkSel, baseSel,
		input delayT, unitSel, tick);
endinterface : dpt_time_if

//--- hw/dpt_tick_gen.sv
// Common time tick in the selected resolution
`timescale 1ns/1ps
module dpt_tick_gen
	import dpt_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYC_DFLT
) (
	input wire logic ref_clk,
	input wire logic rstn,
	dpt_time_if.tickPort tp
);
	logic [31:0] fineCnt_ff;
	logic [7:0] secCnt_ff;
	logic [7:0] minCnt_ff;
	logic tick_ff;
	logic fineWrap;
	logic secWrap;
	logic minWrap;

	assign fineWrap = (fineCnt_ff == 32'(TICK_CYC - 1));
	assign secWrap = fineWrap && (secCnt_ff == 8'(SEC_TICKS - 1));
	assign minWrap = secWrap && (minCnt_ff == 8'(MIN_SECS - 1));

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) fineCnt_ff <= 32'h0000_0000;
		else if (fineWrap) fineCnt_ff <= 32'h0000_0000;
		else fineCnt_ff <= fineCnt_ff + 32'h0000_0001;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) secCnt_ff <= 8'h00;
		else if (secWrap) secCnt_ff <= 8'h00;
		else if (fineWrap) secCnt_ff <= secCnt_ff + 8'h01;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) minCnt_ff <= 8'h00;
		else if (minWrap) minCnt_ff <= 8'h00;
		else if (secWrap) minCnt_ff <= minCnt_ff + 8'h01;
	end

	// Unit tick for all timing; code 3 is not a valid unit
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) tick_ff <= 1'b0;
		else begin
			unique case (tp.unitSel)
				BASE_FINE: tick_ff <= fineWrap;
				BASE_SEC: tick_ff <= secWrap;
				default: tick_ff <= minWrap;
			endcase
		end
	end

	assign tp.tick = tick_ff;

	chk_tick_spacing: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		tick_ff |=> !tick_ff
	) else $error("unit ticks came back to back");
endmodule : dpt_tick_gen

//--- hw/dpt_delay_sel.sv
// Delay source choice, clamping and unit scaling
`timescale 1ns/1ps
module dpt_delay_sel
	import dpt_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [SRC_CNT*EXT_W-1:0] extActualValue,
	dpt_time_if.selPort sp
);
	logic [EXT_W-1:0] srcVal;
	logic [EXT_W-1:0] maxVal;
	logic [EXT_W-1:0] clamped;
	logic [EXT_W-1:0] scaled;
	logic [15:0] delayT_ff;
	logic [1:0] unitSel_ff;

	// Negative values go to zero, large ones to the limit
	function automatic logic [EXT_W-1:0] clampVal(
		input logic [EXT_W-1:0] v,
		input logic [EXT_W-1:0] maxV
	);
		logic [EXT_W-1:0] r;
		if (v[EXT_W-1]) r = EXT_ZERO;
		else if (v > maxV) r = maxV;
		else r = v;
		return r;
	endfunction : clampVal

	always_comb begin
		srcVal = {4'h0, sp.fixedT};
		maxVal = (sp.baseSel == BASE_FINE) ? FIX_MAX_FINE : FIX_MAX_UNIT;
		if (sp.srcExt) begin
			srcVal = extActualValue[sp.blkSel*EXT_W +: EXT_W];
			maxVal = (sp.baseSel == BASE_FINE) ? EXT_MAX_MS : EXT_MAX_UNIT;
		end
		clamped = clampVal(srcVal, maxVal);
		scaled = clamped;
		if (sp.srcExt && sp.baseSel == BASE_FINE)
			scaled = clamped / EXT_MS_PER_TICK;
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) delayT_ff <= DLY_ZERO;
		else delayT_ff <= scaled[DLY_W-1:0];
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) unitSel_ff <= BASE_FINE;
		else if (sp.baseSel == 2'h3) unitSel_ff <= BASE_MIN;
		else unitSel_ff <= sp.baseSel;
	end

	assign sp.delayT = delayT_ff;
	assign sp.unitSel = unitSel_ff;

	chk_ext_clamp: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		sp.srcExt && sp.baseSel == BASE_FINE
		|=> delayT_ff <= FIX_MAX_FINE[DLY_W-1:0]
	) else $error("external delay above fine range");

	chk_ext_unit: assert property (
		@(posedge ref_clk) disable iff (!rstn)
		sp.srcExt && sp.baseSel != BASE_FINE
		|=> delayT_ff <= EXT_MAX_UNIT[DLY_W-1:0]
	) else $error("external delay above unit range");
endmodule : dpt_delay_sel

//--- hw/dpt_timer_top.sv
// Delay and pulse timer block with register port
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module dpt_timer_top
	import dpt_pkg::*;
#(
	parameter int unsigned TICK_CYC = TICK_CYC_DFLT
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [31:0] regRdData,
	input wire logic trgIn,
	input wire logic clrIn,
	input wire logic pwrUpIn,
	input wire logic [SRC_CNT*EXT_W-1:0] extActualValue,
	output logic blockOut
);
	// -----------------------------------------------------------------
	// Declarations
	// -----------------------------------------------------------------
	dpt_time_if tif();
	logic trgMeta_ff, trgSync_ff, trgPrev_ff;
	logic clrMeta_ff, clrSync_ff;
	logic pwrMeta_ff, pwrSync_ff, pwrPrev_ff;
	dpt_mode_e mode_ff;
	logic retain_ff, srcExt_ff;
	logic [1:0] base_ff, blkSel_ff;
	logic [15:0] highDly_ff, lowDly_ff;
	logic [31:0] rdData_ff;
	dpt_state_e state_ff, nxt_state;
	logic [15:0] elapsed_ff, nxt_elapsed;
	logic out_ff, nxt_out;
	logic trgRise, ctrlWr, pwrClr, clrAct, quiet, expired;
	logic [15:0] elapsedInc, curDly;

	// -----------------------------------------------------------------
	// Submodules
	// -----------------------------------------------------------------
	dpt_tick_gen #(
		.TICK_CYC(TICK_CYC)
	) uTick (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.tp(tif.tickPort)
	);

	dpt_delay_sel uSel (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.extActualValue(extActualValue),
		.sp(tif.selPort)
	);
	assign tif.fixedT = highDly_ff;
	assign tif.srcExt = srcExt_ff;
	assign tif.blkSel = blkSel_ff;
	assign tif.baseSel = base_ff;

	// -----------------------------------------------------------------
	// Input synchronisers
	// -----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			trgMeta_ff <= 1'b0;
			trgSync_ff <= 1'b0;
			trgPrev_ff <= 1'b0;
		end else begin
			trgMeta_ff <= trgIn;
			trgSync_ff <= trgMeta_ff;
			trgPrev_ff <= trgSync_ff;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			clrMeta_ff <= 1'b0;
			clrSync_ff <= 1'b0;
		end else begin
			clrMeta_ff <= clrIn;
			clrSync_ff <= clrMeta_ff;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pwrMeta_ff <= 1'b0;
			pwrSync_ff <= 1'b0;
			pwrPrev_ff <= 1'b0;
		end else begin
			pwrMeta_ff <= pwrUpIn;
			pwrSync_ff <= pwrMeta_ff;
			pwrPrev_ff <= pwrSync_ff;
		end
	end

	// Edge against the previous evaluation
	assign trgRise = trgSync_ff && !trgPrev_ff;
	assign pwrClr = pwrSync_ff && !pwrPrev_ff && !retain_ff;
	assign ctrlWr = regWrStb && (regAddr == REG_CTRL);
	assign clrAct = clrSync_ff &&
		(mode_ff == MODE_OFFDLY || mode_ff == MODE_RETON);
	assign quiet = !ctrlWr && !pwrClr;

	// -----------------------------------------------------------------
	// Register writes
	// -----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mode_ff <= MODE_OFFDLY;
			retain_ff <= 1'b0;
			srcExt_ff <= 1'b0;
			base_ff <= BASE_FINE;
		end else if (ctrlWr) begin
			mode_ff <= dpt_mode_e'(regWrData[CTRL_MODE_LSB +: 2]);
			retain_ff <= regWrData[CTRL_RET_BIT];
			srcExt_ff <= regWrData[CTRL_EXT_BIT];
			base_ff <= regWrData[CTRL_BASE_LSB +: 2];
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			highDly_ff <= DLY_ZERO;
			lowDly_ff <= DLY_ZERO;
			blkSel_ff <= 2'h0;
		end else if (regWrStb) begin
			if (regAddr == REG_HIGH) highDly_ff <= regWrData[15:0];
			if (regAddr == REG_LOW) lowDly_ff <= regWrData[15:0];
			if (regAddr == REG_SRC) blkSel_ff <= regWrData[1:0];
		end
	end

	// -----------------------------------------------------------------
	// Register reads
	// -----------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) rdData_ff <= RD_ZERO;
		else if (!regRdStb) rdData_ff <= RD_ZERO;
		else begin
			unique case (regAddr)
				REG_CTRL: rdData_ff <= {26'h000_0000, base_ff,
					srcExt_ff, retain_ff, mode_ff};
				REG_HIGH: rdData_ff <= {16'h0000, highDly_ff};
				REG_LOW: rdData_ff <= {16'h0000, lowDly_ff};
				REG_SRC: rdData_ff <= {30'h0000_0000, blkSel_ff};
				REG_STAT: rdData_ff <= {28'h000_0000, trgSync_ff,
					state_ff, out_ff};
				REG_ELAP: rdData_ff <= {16'h0000, elapsed_ff};
				REG_EFF: rdData_ff <= {16'h0000, tif.delayT};
				default: rdData_ff <= RD_ZERO;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Timing core
	// -----------------------------------------------------------------
	always_comb begin
		elapsedInc = elapsed_ff;
		if (tif.tick && elapsed_ff != DLY_SAT)
			elapsedInc = elapsed_ff + DLY_ONE;
	end
	assign curDly = (state_ff == ST_HOLD) ? lowDly_ff : tif.delayT;
	assign expired = (elapsedInc >= curDly);
	always_comb begin
		nxt_state = state_ff;
		nxt_elapsed = elapsed_ff;
		nxt_out = out_ff;
		unique case (mode_ff)
			MODE_OFFDLY: begin
				if (trgSync_ff) begin
					nxt_state = ST_ON;
					nxt_elapsed = DLY_ZERO;
					nxt_out = 1'b1;
				end else if (state_ff == ST_ON) begin
					nxt_state = ST_TIME;
					nxt_elapsed = DLY_ZERO;
				end else if (state_ff == ST_TIME) begin
					nxt_elapsed = elapsedInc;
					if (expired) begin
						nxt_state = ST_IDLE;
						nxt_out = 1'b0;
					end
				end
				if (clrAct) begin
					nxt_state = ST_IDLE;
					nxt_elapsed = DLY_ZERO;
					nxt_out = 1'b0;
				end
			end
			MODE_ONOFF: begin
				unique case (state_ff)
					ST_IDLE: begin
						if (trgRise) begin
							nxt_state = ST_TIME;
							nxt_elapsed = DLY_ZERO;
						end
					end
					ST_TIME: begin
						if (!trgSync_ff) begin
							nxt_state = ST_IDLE;
							nxt_elapsed = DLY_ZERO;
						end else begin
							nxt_elapsed = elapsedInc;
							if (expired) begin
								nxt_state = ST_ON;
								nxt_out = 1'b1;
							end
						end
					end
					ST_ON: begin
						if (!trgSync_ff) begin
							nxt_state = ST_HOLD;
							nxt_elapsed = DLY_ZERO;
						end
					end
					ST_HOLD: begin
						if (trgSync_ff) begin
							nxt_state = ST_ON;
							nxt_elapsed = DLY_ZERO;
						end else begin
							nxt_elapsed = elapsedInc;
							if (expired) begin
								nxt_state = ST_IDLE;
								nxt_out = 1'b0;
							end
						end
					end
				endcase
			end
			MODE_RETON: begin
				if (state_ff == ST_IDLE && trgRise) begin
					nxt_state = ST_TIME;
					nxt_elapsed = DLY_ZERO;
				end else if (state_ff == ST_TIME) begin
					nxt_elapsed = elapsedInc;
					if (expired) begin
						nxt_state = ST_ON;
						nxt_out = 1'b1;
					end
				end else if (state_ff == ST_HOLD) begin
					nxt_state = ST_IDLE;
				end
				if (clrAct) begin
					nxt_state = ST_IDLE;
					nxt_elapsed = DLY_ZERO;
					nxt_out = 1'b0;
				end
			end
			MODE_PULSE: begin
				if (state_ff == ST_IDLE && trgRise) begin
					nxt_state = ST_TIME;
					nxt_elapsed = DLY_ZERO;
					nxt_out = 1'b1;
				end else if (state_ff == ST_TIME) begin
					nxt_elapsed = elapsedInc;
					if (!trgSync_ff) begin
						nxt_state = ST_IDLE;
						nxt_out = 1'b0;
					end else if (expired) begin
						nxt_state = ST_ON;
						nxt_out = 1'b0;
					end
				end else if (state_ff != ST_IDLE && !trgSync_ff) begin
					nxt_state = ST_IDLE;
				end
			end
		endcase
		if (!quiet) begin
			nxt_state = ST_IDLE;
			nxt_elapsed = DLY_ZERO;
			nxt_out = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) state_ff <= ST_IDLE;
		else state_ff <= nxt_state;
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) elapsed_ff <= DLY_ZERO;
		else elapsed_ff <= nxt_elapsed;
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) out_ff <= 1'b0;
		else out_ff <= nxt_out;
	end
	assign blockOut = out_ff;
	assign regRdData = rdData_ff;

	// -----------------------------------------------------------------
	// Checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	sequence seqOffHigh;
		mode_ff == MODE_OFFDLY && trgSync_ff && !clrAct && quiet;
	endsequence
	sequence seqOffFall;
		mode_ff == MODE_OFFDLY && state_ff == ST_ON && !trgSync_ff
			&& !clrAct && quiet;
	endsequence
	sequence seqPulseRise;
		mode_ff == MODE_PULSE && state_ff == ST_IDLE && trgRise && quiet;
	endsequence
	chk_off_set: assert property (
		seqOffHigh |=> out_ff && state_ff == ST_ON
			&& elapsed_ff == DLY_ZERO
	) else $error("off-delay output not set by trigger");
	chk_off_fall: assert property (
		seqOffFall |=> state_ff == ST_TIME && out_ff
			&& elapsed_ff == DLY_ZERO
	) else $error("off-delay fall did not restart time");
	chk_off_expire: assert property (
		mode_ff == MODE_OFFDLY && state_ff == ST_TIME && !trgSync_ff
			&& !clrAct && quiet && expired |=> !out_ff
	) else $error("off-delay output not cleared at expiry");
	chk_clear_force: assert property (
		clrAct |=> !out_ff && elapsed_ff == DLY_ZERO
	) else $error("clear did not zero output and time");
	chk_power_clear: assert property (
		pwrClr |=> !out_ff && elapsed_ff == DLY_ZERO
			&& state_ff == ST_IDLE
	) else $error("power restore did not clear timer");
	chk_onoff_abort: assert property (
		mode_ff == MODE_ONOFF && state_ff == ST_TIME && !trgSync_ff
			&& quiet |=> state_ff == ST_IDLE && !out_ff
	) else $error("high delay not aborted by early fall");
	chk_onoff_cancel: assert property (
		mode_ff == MODE_ONOFF && state_ff == ST_HOLD && trgSync_ff
			&& quiet |=> state_ff == ST_ON && out_ff
	) else $error("low delay not cancelled by early rise");
	chk_ret_latch: assert property (
		mode_ff == MODE_RETON && state_ff == ST_ON && !clrAct
			&& quiet |=> out_ff && $stable(elapsed_ff)
	) else $error("retentive output or time changed");
	chk_pulse_start: assert property (
		seqPulseRise |=> out_ff && state_ff == ST_TIME
	) else $error("pulse not started by rising trigger");
	chk_pulse_cut: assert property (
		mode_ff == MODE_PULSE && state_ff == ST_TIME && !trgSync_ff
			&& quiet |=> !out_ff
	) else $error("pulse not cut by falling trigger");
endmodule : dpt_timer_top

//--- dv/dpt_src_model.sv
// Upstream circuit model: trigger, clear and power pins, source values
`timescale 1ns/1ps
module dpt_src_model
	import dpt_pkg::*;
(
	input wire logic ref_clk,
	output logic trgIn,
	output logic clrIn,
	output logic pwrUpIn,
	output logic [SRC_CNT*EXT_W-1:0] extActualValue
);
	initial begin
		trgIn = 1'h0;
		clrIn = 1'h0;
		pwrUpIn = 1'h0;
		extActualValue = '0;
	end
	// Pins change only just after a clock edge
	task automatic pins(input logic t, input logic c, input logic p);
		@(posedge ref_clk);
		trgIn <= t;
		clrIn <= c;
		pwrUpIn <= p;
	endtask : pins
	// Live actual value of another block
	task automatic setSrc(input int idx, input logic [EXT_W-1:0] v);
		@(posedge ref_clk);
		extActualValue[idx*EXT_W +: EXT_W] <= v;
	endtask : setSrc
endmodule : dpt_src_model

//--- dv/tb_top.sv
// Self-checking bench of the delay and pulse timer
`timescale 1ns/1ps
module tb_top;
	import dpt_pkg::*;
	localparam int unsigned TCYC = 4;
	typedef struct packed {
		logic [7:0] a;
		logic [31:0] d;
		logic w;
		logic [31:0] e;
	} dpt_row_s;
	typedef struct packed {
		logic [5:0] c;
		logic [19:0] v;
		logic [15:0] e;
	} dpt_ext_s;
	logic ref_clk = 1'h0;
	logic rstn = 1'h0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0000_0000;
	logic regWrStb = 1'h0;
	logic regRdStb = 1'h0;
	logic [31:0] regRdData;
	logic trgIn;
	logic clrIn;
	logic pwrUpIn;
	logic blockOut;
	logic [SRC_CNT*EXT_W-1:0] extActualValue;
	logic [31:0] rd;
	int numErrors = 0;
	int cmpCount = 0;
	dpt_row_s rows[8] = '{
		'{REG_CTRL, 32'h0000_0000, 1'h0, 32'h0000_0000},
		'{REG_HIGH, 32'h0001_2345, 1'h1, 32'h0000_2345},
		'{REG_LOW, 32'hFFFF_0007, 1'h1, 32'h0000_0007},
		'{REG_SRC, 32'h0000_0007, 1'h1, 32'h0000_0003},
		'{REG_CTRL, 32'h0000_002E, 1'h1, 32'h0000_002E},
		'{REG_STAT, 32'h0000_00FF, 1'h1, 32'h0000_0000},
		'{REG_ELAP, 32'h0000_1234, 1'h1, 32'h0000_0000},
		'{8'h1C, 32'hFFFF_FFFF, 1'h1, 32'h0000_0000}};
	dpt_ext_s ext[6] = '{
		'{6'h08, 20'hF_FFFB, 16'h0000},
		'{6'h08, 20'h3_0D40, 16'h270F},
		'{6'h08, 20'h0_001E, 16'h0003},
		'{6'h18, 20'h0_1B58, 16'h176F},
		'{6'h28, 20'h0_002A, 16'h002A},
		'{6'h38, 20'h0_1B58, 16'h176F}};

	dpt_timer_top #(.TICK_CYC(TCYC)) dpt_timer_top_inst (
		.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
		.regRdData(regRdData), .trgIn(trgIn), .clrIn(clrIn),
		.pwrUpIn(pwrUpIn), .extActualValue(extActualValue),
		.blockOut(blockOut));
	dpt_src_model dpt_src_model_inst (
		.ref_clk(ref_clk), .trgIn(trgIn), .clrIn(clrIn),
		.pwrUpIn(pwrUpIn), .extActualValue(extActualValue));

	always #2.5 ref_clk = ~ref_clk;

	task automatic endSim;
		if (numErrors == 0 && cmpCount > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : endSim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmpCount++;
		if (got !== exp) begin
			numErrors++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic regWr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'h1;
		@(posedge ref_clk);
		regWrStb <= 1'h0;
	endtask : regWr
	task automatic regRd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regRdStb <= 1'h1;
		@(posedge ref_clk);
		regRdStb <= 1'h0;
		#1;
		d = regRdData;
	endtask : regRd
	task automatic cfg(input logic [5:0] c, input logic [15:0] t);
		regWr(REG_HIGH, {16'h0000, t});
		regWr(REG_LOW, {16'h0000, t});
		regWr(REG_CTRL, {26'h000_0000, c});
	endtask : cfg
	task automatic pins(input logic t, input logic c, input logic p);
		dpt_src_model_inst.pins(t, c, p);
	endtask : pins
	// Output keeps its old level two edges, takes the new one at the third
	task automatic edge3(input logic lvl);
		repeat (2) @(posedge ref_clk);
		#1;
		chk({31'h0000_0000, blockOut}, {31'h0000_0000, ~lvl});
		@(posedge ref_clk);
		#1;
		chk({31'h0000_0000, blockOut}, {31'h0000_0000, lvl});
	endtask : edge3
	task automatic hold(input logic lvl, input int n);
		logic bad;
		bad = 1'h0;
		repeat (n) begin
			@(posedge ref_clk);
			#1;
			if (blockOut !== lvl)
				bad = 1'h1;
		end
		chk({31'h0000_0000, bad}, 32'h0000_0000);
	endtask : hold
	task automatic waitTo(input logic lvl, input int n);
		int i;
		for (i = 0; i < n && blockOut !== lvl; i++) begin
			@(posedge ref_clk);
			#1;
		end
		chk({31'h0000_0000, blockOut}, {31'h0000_0000, lvl});
		if (blockOut !== lvl)
			endSim();
	endtask : waitTo

	initial begin
		repeat (12) @(posedge ref_clk);
		chk(regRdData, RD_ZERO);
		chk({31'h0000_0000, blockOut}, 32'h0000_0000);
		rstn <= 1'h1;
		foreach (rows[i]) begin
			if (rows[i].w)
				regWr(rows[i].a, rows[i].d);
			regRd(rows[i].a, rd);
			chk(rd, rows[i].e);
		end
		// Off-delay
		cfg(6'h00, 16'h0003);
		pins(1, 0, 0);
		edge3(1);
		repeat (10) @(posedge ref_clk);
		pins(0, 0, 0);
		hold(1, 2*TCYC);
		waitTo(0, 3*TCYC);
		cfg(6'h00, 16'h0006);
		pins(1, 0, 0);
		repeat (4) @(posedge ref_clk);
		pins(0, 0, 0);
		repeat (16) @(posedge ref_clk);
		pins(1, 0, 0);
		repeat (3) @(posedge ref_clk);
		pins(0, 0, 0);
		hold(1, 5*TCYC);
		waitTo(0, 6*TCYC);
		pins(1, 0, 0);
		repeat (5) @(posedge ref_clk);
		pins(0, 0, 0);
		repeat (4) @(posedge ref_clk);
		pins(0, 1, 0);
		edge3(0);
		regRd(REG_ELAP, rd);
		chk(rd, 32'h0000_0000);
		pins(0, 0, 0);
		// On/off-delay
		cfg(6'h01, 16'h0003);
		pins(1, 0, 0);
		repeat (3) @(posedge ref_clk);
		pins(0, 0, 0);
		hold(0, 30);
		pins(1, 0, 0);
		hold(0, 2*TCYC);
		waitTo(1, 3*TCYC);
		pins(0, 0, 0);
		repeat (3) @(posedge ref_clk);
		pins(1, 0, 0);
		hold(1, 30);
		pins(0, 0, 0);
		hold(1, 2*TCYC);
		waitTo(0, 3*TCYC);
		// Retentive on-delay, second pulse must not restart timing
		cfg(6'h02, 16'h0006);
		pins(1, 0, 0);
		repeat (2) @(posedge ref_clk);
		pins(0, 0, 0);
		repeat (10) @(posedge ref_clk);
		pins(1, 0, 0);
		repeat (2) @(posedge ref_clk);
		pins(0, 0, 0);
		waitTo(1, 16);
		pins(1, 0, 0);
		hold(1, 20);
		pins(0, 1, 0);
		edge3(0);
		regRd(REG_ELAP, rd);
		chk(rd, 32'h0000_0000);
		pins(0, 0, 0);
		// Power restore, without and with retention
		cfg(6'h02, 16'h0001);
		pins(1, 0, 0);
		waitTo(1, 3*TCYC);
		pins(0, 0, 1);
		waitTo(0, 6);
		pins(0, 0, 0);
		cfg(6'h06, 16'h0001);
		pins(1, 0, 0);
		waitTo(1, 3*TCYC);
		pins(0, 0, 1);
		hold(1, 20);
		pins(0, 1, 0);
		waitTo(0, 6);
		pins(0, 0, 0);
		// Pulse: full length, then cut short
		cfg(6'h03, 16'h0003);
		pins(1, 0, 0);
		edge3(1);
		hold(1, 6);
		waitTo(0, 14);
		pins(0, 0, 0);
		repeat (4) @(posedge ref_clk);
		pins(1, 0, 0);
		edge3(1);
		repeat (2) @(posedge ref_clk);
		pins(0, 0, 0);
		edge3(0);
		// Second unit base: two unit ticks need 401 to 800 cycles
		cfg(6'h13, 16'h0002);
		pins(1, 0, 0);
		edge3(1);
		hold(1, 100*TCYC);
		waitTo(0, 105*TCYC);
		pins(0, 0, 0);
		// Delay from another block, clamped and scaled
		dpt_src_model_inst.setSrc(0, 20'h0_0777);
		regWr(REG_SRC, 32'h0000_0001);
		foreach (ext[i]) begin
			dpt_src_model_inst.setSrc(1, ext[i].v);
			regWr(REG_CTRL, {26'h000_0000, ext[i].c});
			repeat (3) @(posedge ref_clk);
			regRd(REG_EFF, rd);
			chk(rd, {16'h0000, ext[i].e});
		end
		// Reset in mid-run
		cfg(6'h00, 16'h0003);
		pins(1, 0, 0);
		waitTo(1, 6);
		rstn <= 1'h0;
		#1;
		chk({31'h0000_0000, blockOut}, 32'h0000_0000);
		chk(regRdData, RD_ZERO);
		pins(0, 0, 0);
		repeat (3) @(posedge ref_clk);
		rstn <= 1'h1;
		hold(0, 6);
		regRd(REG_CTRL, rd);
		chk(rd, 32'h0000_0000);
		regRd(REG_HIGH, rd);
		chk(rd, 32'h0000_0000);
		endSim();
	end
endmodule : tb_top
